// *** dpsw_regs.vh ***
// Timing constants for the dual-port SRAM host controller
`ifndef DPSW_REGS_VH
`define DPSW_REGS_VH
`define DPSW_CLK_PERIOD_PS 5000
`define DPSW_T_WC_PS 10000
`define DPSW_T_WP_PS 8000
`define DPSW_T_WZ_PS 4000
`define DPSW_T_DW_PS 6000
`define DPSW_T_WH_PS 8000
`define DPSW_T_HZ_PS 4000
`define DPSW_T_AA_PS 10000
`define DPSW_T_SWRD_PS 5000
`define DPSW_T_DDD_PS 20000
`define DPSW_CYC_UP(t) (((t) + `DPSW_CLK_PERIOD_PS - 1) / `DPSW_CLK_PERIOD_PS)
`define DPSW_CYC_WC `DPSW_CYC_UP(`DPSW_T_WC_PS)
`define DPSW_CYC_WP `DPSW_CYC_UP(`DPSW_T_WP_PS)
`define DPSW_CYC_WZDW `DPSW_CYC_UP(`DPSW_T_WZ_PS + `DPSW_T_DW_PS)
`define DPSW_CYC_WH `DPSW_CYC_UP(`DPSW_T_WH_PS)
`define DPSW_CYC_HZ `DPSW_CYC_UP(`DPSW_T_HZ_PS)
`define DPSW_CYC_RD `DPSW_CYC_UP(`DPSW_T_AA_PS)
`define DPSW_CYC_SWRD `DPSW_CYC_UP(`DPSW_T_SWRD_PS)
`define DPSW_CYC_DDD `DPSW_CYC_UP(`DPSW_T_DDD_PS)
`define DPSW_CNT_W 4
`endif

// *** dpsw_cnt.v ***
// Down counter used for pin timing
`timescale 1ns/100ps
module dpsw_cnt #(
    parameter W = 4
) (
    clk_sys,
    reset,
    load,
    load_val,
    done
);
    input wire clk_sys;
    input wire reset;
    input wire load;
    input wire [W-1:0] load_val;
    output wire done;
    reg [W-1:0] cnt_ff;
    assign done = (cnt_ff == {W{1'b0}});
    always @(posedge clk_sys) begin
        if (reset) begin
            cnt_ff <= {W{1'b0}};
        end else if (load) begin
            cnt_ff <= load_val;
        end else if (cnt_ff != {W{1'b0}}) begin
            cnt_ff <= cnt_ff - {{(W-1){1'b0}}, 1'b1};
        end
    end
endmodule

// *** dpsw_host.v ***
// Host controller for one port of an asynchronous dual-port SRAM
`timescale 1ns/100ps
`include "dpsw_regs.vh"
//////////////////////////////////////////////////////////////////////////////
module dpsw_host #(
    parameter AW = 18,
    parameter DW = 36,
    parameter BW = 4
) (
    clk_sys,
    reset,
    req_valid,
    req_ready,
    req_write,
    req_sem,
    req_burst_last,
    req_addr,
    req_wdata,
    req_be,
    rsp_valid,
    rsp_rdata,
    sram_addr,
    sram_chip_enable_low_active,
    sram_chip_enable_high_active,
    sram_flag_select_n,
    sram_rw_n,
    sram_oe_n,
    sram_byte_lane_enable_n,
    sram_dq_in,
    sram_dq_out,
    sram_dq_oe,
    sram_busy_n
);
    input wire clk_sys;
    input wire reset;
    input wire req_valid;
    output wire req_ready;
    input wire req_write;
    input wire req_sem;
    input wire req_burst_last;
    input wire [AW-1:0] req_addr;
    input wire [DW-1:0] req_wdata;
    input wire [BW-1:0] req_be;
    output reg rsp_valid;
    output reg [DW-1:0] rsp_rdata;
    output reg [AW-1:0] sram_addr;
    output reg sram_chip_enable_low_active;
    output reg sram_chip_enable_high_active;
    output reg sram_flag_select_n;
    output reg sram_rw_n;
    output reg sram_oe_n;
    output reg [BW-1:0] sram_byte_lane_enable_n;
    input wire [DW-1:0] sram_dq_in;
    output reg [DW-1:0] sram_dq_out;
    output reg sram_dq_oe;
    input wire sram_busy_n;

    localparam [5:0] ST_IDLE = 6'h01;
    localparam [5:0] ST_RD = 6'h02;
    localparam [5:0] ST_TURN = 6'h04;
    localparam [5:0] ST_WR = 6'h08;
    localparam [5:0] ST_WHOLD = 6'h10;
    localparam [5:0] ST_REC = 6'h20;
    localparam integer CYC_RD = `DPSW_CYC_RD;
    localparam integer CYC_HZ = `DPSW_CYC_HZ;
    localparam integer CYC_WP = `DPSW_CYC_WP;
    localparam integer CYC_WC = `DPSW_CYC_WC;
    localparam integer CYC_WZDW = `DPSW_CYC_WZDW;
    localparam integer CYC_WH = `DPSW_CYC_WH;
    localparam integer CYC_SWRD = `DPSW_CYC_SWRD;
    localparam [3:0] C_RD = CYC_RD[3:0];
    localparam [3:0] C_HZ = CYC_HZ[3:0];
    localparam [3:0] C_WP = CYC_WP[3:0];
    localparam [3:0] C_WC = CYC_WC[3:0];
    localparam [3:0] C_WZDW = CYC_WZDW[3:0];
    localparam [3:0] C_WH = CYC_WH[3:0];
    localparam [3:0] C_SWRD = CYC_SWRD[3:0];

    function [3:0] max4;
        input [3:0] a;
        input [3:0] b;
        begin
            max4 = (a > b) ? a : b;
        end
    endfunction

    reg [5:0] state_ff;
    reg [5:0] nxt_state;
    reg burst_ff;
    reg sem_ff;
    reg busy_s1_ff;
    reg busy_s2_ff;
    reg [DW-1:0] dq_s1_ff;
    reg [DW-1:0] dq_s2_ff;
    reg cnt_load;
    reg [3:0] cnt_val;
    wire cnt_done;

    dpsw_cnt #(.W(`DPSW_CNT_W)) u_cnt (
        .clk_sys(clk_sys),
        .reset(reset),
        .load(cnt_load),
        .load_val(cnt_val),
        .done(cnt_done)
    );

    // Pin inputs synchronised
    always @(posedge clk_sys) begin
        if (reset) begin
            busy_s1_ff <= 1'b1;
            busy_s2_ff <= 1'b1;
            dq_s1_ff <= {DW{1'b0}};
            dq_s2_ff <= {DW{1'b0}};
        end else begin
            busy_s1_ff <= sram_busy_n;
            busy_s2_ff <= busy_s1_ff;
            dq_s1_ff <= sram_dq_in;
            dq_s2_ff <= dq_s1_ff;
        end
    end

    // Accept next burst word only at end of write cycle time
    assign req_ready = (state_ff == ST_IDLE) ||
                       (state_ff == ST_WR && burst_ff && cnt_done && busy_s2_ff);

    //////////////////////////////////////////////////////////////////////////
    // Control sequencer
    always @* begin
        nxt_state = state_ff;
        cnt_load = 1'b0;
        cnt_val = 4'h0;
        case (state_ff)
            ST_IDLE: begin
                if (req_valid) begin
                    cnt_load = 1'b1;
                    if (req_write) begin
                        nxt_state = ST_TURN;
                        cnt_val = C_HZ;
                    end else begin
                        nxt_state = ST_RD;
                        cnt_val = req_sem ? max4(C_RD, C_SWRD) : C_RD;
                    end
                end
            end
            ST_RD: begin
                if (cnt_done) begin
                    nxt_state = ST_REC;
                    cnt_load = 1'b1;
                    cnt_val = C_HZ;
                end
            end
            ST_TURN: begin
                if (cnt_done) begin
                    nxt_state = ST_WR;
                    cnt_load = 1'b1;
                    cnt_val = max4(C_WC, max4(C_WP, C_WZDW));
                end
            end
            ST_WR: begin
                if (!busy_s2_ff) begin
                    cnt_load = 1'b1;
                    cnt_val = C_WH;
                    nxt_state = ST_WHOLD;
                end else if (cnt_done) begin
                    if (burst_ff && req_valid && req_write) begin
                        cnt_load = 1'b1;
                        cnt_val = C_WC;
                    end else begin
                        nxt_state = ST_REC;
                        cnt_load = 1'b1;
                        cnt_val = 4'h1;
                    end
                end
            end
            ST_WHOLD: begin
                if (!busy_s2_ff) begin
                    cnt_load = 1'b1;
                    cnt_val = C_WH;
                end else if (cnt_done) begin
                    nxt_state = ST_WR;
                    cnt_load = 1'b1;
                    cnt_val = 4'h1;
                end
            end
            ST_REC: begin
                if (cnt_done) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // Pin and response registers
    always @(posedge clk_sys) begin
        if (reset) begin
            state_ff <= ST_IDLE;
            burst_ff <= 1'b0;
            sem_ff <= 1'b0;
            rsp_valid <= 1'b0;
            rsp_rdata <= {DW{1'b0}};
            sram_addr <= {AW{1'b0}};
            sram_chip_enable_low_active <= 1'b1;
            sram_chip_enable_high_active <= 1'b0;
            sram_flag_select_n <= 1'b1;
            sram_rw_n <= 1'b1;
            sram_oe_n <= 1'b1;
            sram_byte_lane_enable_n <= {BW{1'b1}};
            sram_dq_out <= {DW{1'b0}};
            sram_dq_oe <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            rsp_valid <= 1'b0;
            if (state_ff == ST_IDLE && req_valid) begin
                // Address set on the same edge as the enables assert
                sram_addr <= req_addr;
                sem_ff <= req_sem;
                burst_ff <= req_write && !req_sem && !req_burst_last;
                sram_chip_enable_low_active <= req_sem;
                sram_chip_enable_high_active <= !req_sem;
                sram_flag_select_n <= !req_sem;
                sram_byte_lane_enable_n <= ~req_be;
                sram_oe_n <= req_write;
                // Write select falls with enables so outputs stay off
                sram_rw_n <= !req_write;
                sram_dq_out <= req_wdata;
            end
            if (state_ff == ST_TURN && cnt_done) begin
                sram_dq_oe <= 1'b1;
            end
            if (state_ff == ST_WR && busy_s2_ff && cnt_done && burst_ff &&
                req_valid && req_write) begin
                // Next burst word with enables held active
                sram_addr <= req_addr;
                sram_dq_out <= req_wdata;
                sram_byte_lane_enable_n <= ~req_be;
                burst_ff <= !req_burst_last;
            end
            if (state_ff == ST_RD && cnt_done) begin
                rsp_valid <= 1'b1;
                // Semaphore flag is replicated on every data bit
                rsp_rdata <= sem_ff ? {DW{dq_s2_ff[0]}} : dq_s2_ff;
            end
            if (nxt_state == ST_REC && state_ff != ST_REC) begin
                // Write select and all enables except sram_dq_oe deassert on the same edge to end the access
                sram_rw_n <= 1'b1;
                sram_chip_enable_low_active <= 1'b1;
                sram_chip_enable_high_active <= 1'b0;
                sram_flag_select_n <= 1'b1;
                sram_byte_lane_enable_n <= {BW{1'b1}};
                sram_oe_n <= 1'b1;
            end
            if (state_ff == ST_REC && cnt_done) begin
                sram_dq_oe <= 1'b0;
            end
        end
    end
endmodule

// *** dpsw_host_assertions.sv ***
// Pin-level checks for the SRAM host controller
`timescale 1ns/100ps
module dpsw_host_assertions #(
    parameter AW = 18,
    parameter DW = 36,
    parameter BW = 4
) (
    input wire clk_sys,
    input wire reset,
    input wire req_valid,
    input wire req_ready,
    input wire req_write,
    input wire req_sem,
    input wire rsp_valid,
    input wire [DW-1:0] rsp_rdata,
    input wire [AW-1:0] sram_addr,
    input wire sram_chip_enable_low_active,
    input wire sram_chip_enable_high_active,
    input wire sram_flag_select_n,
    input wire sram_rw_n,
    input wire sram_oe_n,
    input wire sram_dq_oe,
    input wire sram_busy_n
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);
    wire arr_sel = !sram_chip_enable_low_active && sram_chip_enable_high_active;
    ////////////////////////////////////////////////////////////
    // Multi-step behaviours
    sequence s_sem_read;
        req_valid && req_ready && !req_write && req_sem;
    endsequence
    sequence s_write_held;
        !sram_rw_n [*3];
    endsequence
    ////////////////////////////////////////////////////////////
    a_no_drive_read: assert property (!sram_oe_n |-> !sram_dq_oe)
        else $error("data driven while device output on");
    a_late_data_drive: assert property ($fell(sram_rw_n) |-> !sram_dq_oe)
        else $error("data driven at write start");
    a_enable_with_write: assert property ($fell(sram_rw_n) |->
        $past(sram_chip_enable_low_active) && $past(sram_flag_select_n))
        else $error("enable fell before write select");
    a_oe_off_write: assert property (!sram_rw_n |-> sram_oe_n)
        else $error("output enable low in write");
    a_one_target: assert property (!sram_rw_n |-> arr_sel != !sram_flag_select_n)
        else $error("array and flag selection clash");
    a_burst_addr_hold: assert property ($changed(sram_addr) && !sram_rw_n |=>
        $stable(sram_addr) [*2])
        else $error("address held too short");
    a_sem_read_all: assert property (s_sem_read |-> ##4 rsp_valid &&
        rsp_rdata == {DW{rsp_rdata[0]}})
        else $error("flag not on every data bit");
    a_busy_write_hold: assert property ($rose(sram_busy_n) && !sram_rw_n |->
        s_write_held)
        else $error("write ended too soon after busy");
    a_write_end_whole: assert property ($rose(sram_rw_n) |->
        sram_chip_enable_low_active && sram_flag_select_n)
        else $error("selection outlived write");
endmodule
bind dpsw_host dpsw_host_assertions #(.AW(AW), .DW(DW), .BW(BW)) u_dpsw_host_assertions (.*);

// *** dpsw_sram_model.sv ***
// Behavioural model of the device side of one SRAM port
`timescale 1ns/100ps
module dpsw_sram_model #(
    parameter DW = 36
) (
    input wire clk_sys,
    input wire [17:0] addr,
    input wire chip_en_lo,
    input wire chip_en_hi,
    input wire flag_sel_n,
    input wire rw_n,
    input wire oe_n,
    input wire [3:0] be_n,
    input wire [DW-1:0] wdata,
    input wire wdata_oe,
    input wire block,
    input wire other_sem,
    output wire [DW-1:0] rdata,
    output wire busy_n
);
    logic [DW-1:0] mem [0:63];
    logic [DW-1:0] last_ff = '0;
    logic [DW-1:0] d_q;
    logic [5:0] a_q;
    logic [3:0] be_q;
    logic flag = 1'b1;
    logic wr_q = 1'b0;
    logic sem_q = 1'b0;
    wire arr = !chip_en_lo && chip_en_hi && flag_sel_n;
    wire flag_select_n = !(!chip_en_lo && chip_en_hi) && !flag_sel_n;
    wire wr = (arr || flag_select_n) && !rw_n && wdata_oe && !block;
    wire rd = (arr || flag_select_n) && rw_n && !oe_n;
    assign rdata = rd ? (flag_select_n ? {DW{flag}} : mem[addr[5:0]]) : ~last_ff;
    assign busy_n = !block;
    initial begin
        for (int i = 0; i < 64; i++) begin
            mem[i] = '0;
        end
    end
    always @(posedge clk_sys) begin
        if (rd) begin
            last_ff <= rdata;
        end
        if (wr_q && (!wr || addr[5:0] != a_q)) begin
            if (sem_q) begin
                flag <= d_q[0] || other_sem;
            end else begin
                for (int b = 0; b < 4; b++) begin
                    if (!be_q[b]) begin
                        mem[a_q][b*9 +: 9] <= d_q[b*9 +: 9];
                    end
                end
            end
        end
        wr_q <= wr;
        a_q <= addr[5:0];
        d_q <= wdata;
        be_q <= be_n;
        sem_q <= flag_select_n;
    end
endmodule

// *** dual_port_sram_write_arbitration_tb_top.sv ***
// Self-checking testbench for the SRAM host controller
`timescale 1ns/100ps
module dual_port_sram_write_arbitration_tb_top;
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic req_sem = 1'b0;
    logic req_burst_last = 1'b1;
    logic [17:0] req_addr = '0;
    logic [35:0] req_wdata = '0;
    logic [3:0] req_be = 4'hf;
    logic hold_busy = 1'b0;
    logic other_sem = 1'b0;
    wire req_ready, rsp_valid, sram_chip_enable_low_active, sram_chip_enable_high_active;
    wire sram_flag_select_n, sram_rw_n, sram_oe_n, sram_dq_oe, sram_busy_n;
    wire [35:0] rsp_rdata, sram_dq_in, sram_dq_out;
    wire [17:0] sram_addr;
    wire [3:0] sram_byte_lane_enable_n;
    int fails = 0;
    int n_tests = 0;
    dpsw_host u_dpsw_host (.*);
    dpsw_sram_model u_dpsw_sram_model (
        .clk_sys(clk_sys), .addr(sram_addr), .chip_en_lo(sram_chip_enable_low_active),
        .chip_en_hi(sram_chip_enable_high_active), .flag_sel_n(sram_flag_select_n),
        .rw_n(sram_rw_n),
        .oe_n(sram_oe_n), .be_n(sram_byte_lane_enable_n), .wdata(sram_dq_out),
        .wdata_oe(sram_dq_oe), .block(hold_busy), .other_sem(other_sem),
        .rdata(sram_dq_in), .busy_n(sram_busy_n)
    );
    task automatic end_of_test;
        if (fails == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic cmp(input logic [35:0] got, input logic [35:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic timeout;
        cmp(36'h0, 36'h1);
        end_of_test();
    endtask
    task automatic send(input logic w, s, last, input logic [17:0] a, input logic [35:0] d,
                        input logic [3:0] b);
        int i;
        req_valid <= 1'b1;
        req_write <= w;
        req_sem <= s;
        req_burst_last <= last;
        req_addr <= a;
        req_wdata <= d;
        req_be <= b;
        i = 0;
        do begin
            @(posedge clk_sys);
            i++;
        end while (req_ready !== 1'b1 && i < 100);
        if (i == 100) begin
            timeout();
        end
        req_valid <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rd(input logic s, input logic [17:0] a, input logic [35:0] exp);
        int i;
        send(1'b0, s, 1'b1, a, 36'h0, 4'hf);
        for (i = 0; i < 20 && rsp_valid !== 1'b1; i++) begin
            @(posedge clk_sys);
        end
        if (i == 20) begin
            timeout();
        end
        cmp(rsp_rdata, exp);
    endtask
    ////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_write_read;
        send(1'b1, 1'b0, 1'b1, 18'h3, 36'h123456789, 4'hf);
        send(1'b1, 1'b0, 1'b1, 18'h4, 36'h0abcdef01, 4'hf);
        rd(1'b0, 18'h3, 36'h123456789);
        rd(1'b0, 18'h4, 36'h0abcdef01);
        send(1'b1, 1'b0, 1'b1, 18'h3, 36'hfffffffff, 4'h2);
        rd(1'b0, 18'h3, 36'h123456789 | 36'h00003fe00);
    endtask
    task automatic t_burst;
        send(1'b1, 1'b0, 1'b0, 18'h8, 36'h111111111, 4'hf);
        send(1'b1, 1'b0, 1'b0, 18'h9, 36'h222222222, 4'hf);
        send(1'b1, 1'b0, 1'b1, 18'ha, 36'h333333333, 4'hf);
        rd(1'b0, 18'h8, 36'h111111111);
        rd(1'b0, 18'h9, 36'h222222222);
        rd(1'b0, 18'ha, 36'h333333333);
    endtask
    task automatic t_sem;
        send(1'b1, 1'b1, 1'b1, 18'h0, 36'h0, 4'hf);
        rd(1'b1, 18'h0, 36'h0);
        send(1'b1, 1'b1, 1'b1, 18'h0, 36'h1, 4'hf);
        rd(1'b1, 18'h0, 36'hfffffffff);
        other_sem <= 1'b1;
        send(1'b1, 1'b1, 1'b1, 18'h0, 36'h0, 4'hf);
        rd(1'b1, 18'h0, 36'hfffffffff);
        other_sem <= 1'b0;
    endtask
    task automatic t_busy;
        hold_busy <= 1'b1;
        send(1'b1, 1'b0, 1'b1, 18'h5, 36'h5a5a5a5a5, 4'hf);
        repeat (10) @(posedge clk_sys);
        cmp(u_dpsw_sram_model.mem[5], 36'h0);
        hold_busy <= 1'b0;
        rd(1'b0, 18'h5, 36'h5a5a5a5a5);
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        forever begin
            #2.5 clk_sys = ~clk_sys;
        end
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        @(posedge clk_sys);
        cmp({26'h0, sram_rw_n, sram_oe_n, sram_chip_enable_low_active,
             sram_chip_enable_high_active, sram_flag_select_n, sram_dq_oe,
             sram_byte_lane_enable_n}, 36'h3af);
        t_write_read();
        t_burst();
        t_sem();
        t_busy();
        end_of_test();
    end
endmodule
